//--- include/page_status_pkg.sv
// constants for the page select and status register bank
package page_status_pkg;
  // page control layout
  localparam int          PAGE_W          = 3;
  localparam int          LOCAL_W         = 7;
  localparam int          ADDR_W          = 9;
  localparam int          AUTO_RETURN_BIT = 7;
  localparam int          WRITE_MODE_BIT  = 6;
  localparam logic [2:0]  PAGE_ZERO       = 3'h0;
  localparam logic [2:0]  PAGE_MAX        = 3'h2;
  localparam logic [7:0]  PAGE_CTRL_MASK  = 8'hc7;
  localparam logic [7:0]  PAGE_CTRL_RST   = 8'h00;
  localparam logic [6:0]  PAGE_CTRL_LOCAL = 7'h00;

  // status registers
  localparam logic [8:0]  INPUT_LEVEL_ADDR  = 9'h050;
  localparam logic [8:0]  FAULT_POWER_ADDR  = 9'h051;
  localparam int          GEN_INPUTS        = 5;
  localparam int          CONV_B_ILIM_BIT   = 5;
  localparam int          CONV_A_ILIM_BIT   = 4;
  localparam int          TSD_BIT           = 3;
  localparam int          TWARN_BIT         = 2;
  localparam int          PGOOD_B_BIT       = 1;
  localparam int          PGOOD_A_BIT       = 0;

  // plain read/write registers held by the bank
  localparam int          NUM_RW    = 20;
  localparam int          RW_IDX_W  = 5;
  localparam logic [7:0]  RW_RST    = 8'h00;
  localparam logic [8:0]  RW_ADDR [NUM_RW] = '{
    9'h05e, 9'h0d1, 9'h0d2, 9'h0d3, 9'h0d5, 9'h0d6, 9'h0d7, 9'h0d8, 9'h0d9, 9'h0da,
    9'h101, 9'h104, 9'h105, 9'h140, 9'h143, 9'h144, 9'h145, 9'h146, 9'h147, 9'h148};

  localparam logic [7:0]  READ_NONE = 8'h00;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_ADDR = 2'b01,
    FR_DATA = 2'b10
  } frame_state_t;
endpackage : page_status_pkg

//--- src/page_status_regs.sv
// page selection, register storage and live status for the host register bank
// Notes on behaviour
// - auto-return clears page after access completes
// - write-mode bit picks page or repeated write
// - four-wire frames ignore the write-mode bit
// - page 0/1/2 reach their own address windows
// - status reads return live sampled signals
// - status bit 5 follows converter B limit
// - status bit 4 follows converter A limit
// - status bit 3 follows thermal shutdown
// - status bit 2 follows thermal warning
// - repeated write alternates address and data
// - write-mode change applies from next frame
// - page write advances pointer per data byte
`timescale 1ns/1ps
`default_nettype none
module page_status_regs
  import page_status_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // frame events from the serial front end
  input  wire logic               frame_start,
  input  wire logic               frame_stop,
  input  wire logic               wire4_sel,
  // received byte strobe
  input  wire logic               byte_valid,
  input  wire logic [7:0]         byte_data,
  // read request and answer
  input  wire logic               rd_req,
  output logic      [7:0]         rd_data,
  output logic                    rd_valid,
  output logic                    byte_ack,
  // monitored signals, asynchronous
  input  wire logic [GEN_INPUTS-1:0] gen_input,
  input  wire logic               conv_a_current_limited,
  input  wire logic               conv_b_current_limited,
  input  wire logic               thermal_shutdown_flag,
  input  wire logic               thermal_warn_flag,
  input  wire logic               conv_a_power_good,
  input  wire logic               conv_b_power_good,
  // page control state
  output logic      [PAGE_W-1:0]  page_sel,
  output logic                    write_mode
);

  frame_state_t          state_r;
  logic                  repeat_r;
  logic [LOCAL_W-1:0]    ptr_r;
  logic [7:0]            page_ctrl_r;
  logic [7:0]            rw_regs_r [NUM_RW];
  logic [7:0]            rd_data_r;
  logic                  rd_valid_r;
  logic                  ack_r;
  logic [PAGE_W-1:0]     page_sel_r;
  logic                  write_mode_r;

  // synchroniser stages for the monitored signals
  logic [GEN_INPUTS-1:0] gen_s1_r;
  logic [GEN_INPUTS-1:0] gen_s2_r;
  logic [5:0]            flt_s1_r;
  logic [5:0]            flt_s2_r;

  logic                  in_frame;
  logic                  byte_taken;
  logic                  data_write;
  logic [ADDR_W-1:0]     cur_addr;
  logic                  map_ok;
  logic                  is_page_ctrl;
  logic                  rw_hit;
  logic [RW_IDX_W-1:0]   rw_idx;
  logic [7:0]            fault_live;
  logic [7:0]            input_live;
  logic [7:0]            rd_nxt;

  always_ff @(posedge clock) begin
    if (rst) begin
      gen_s1_r <= '0;
      gen_s2_r <= '0;
      flt_s1_r <= '0;
      flt_s2_r <= '0;
    end else begin
      gen_s1_r <= gen_input;
      gen_s2_r <= gen_s1_r;
      flt_s1_r <= {conv_b_current_limited, conv_a_current_limited, thermal_shutdown_flag,
                   thermal_warn_flag, conv_b_power_good, conv_a_power_good};
      flt_s2_r <= flt_s1_r;
    end
  end

  // live status images, reserved bits zero
  always_comb begin
    input_live = READ_NONE;
    input_live[GEN_INPUTS-1:0] = gen_s2_r;
    fault_live = READ_NONE;
    fault_live[CONV_B_ILIM_BIT] = flt_s2_r[5];
    fault_live[CONV_A_ILIM_BIT] = flt_s2_r[4];
    fault_live[TSD_BIT]         = flt_s2_r[3];
    fault_live[TWARN_BIT]       = flt_s2_r[2];
    fault_live[PGOOD_B_BIT]     = flt_s2_r[1];
    fault_live[PGOOD_A_BIT]     = flt_s2_r[0];
  end

  // address window from page and local pointer
  always_comb begin
    map_ok       = (page_ctrl_r[PAGE_W-1:0] <= PAGE_MAX);
    cur_addr     = {page_ctrl_r[1:0], ptr_r};
    is_page_ctrl = (ptr_r == PAGE_CTRL_LOCAL);
    rw_hit       = 1'b0;
    rw_idx       = '0;
    for (int i = 0; i < NUM_RW; i++) begin
      if (RW_ADDR[i] == cur_addr) begin
        rw_hit = map_ok;
        rw_idx = RW_IDX_W'(i);
      end
    end
  end

  assign in_frame   = (state_r != FR_IDLE);
  assign byte_taken = byte_valid && in_frame && !frame_start && !frame_stop;
  assign data_write = byte_taken && (state_r == FR_DATA);

  // frame sequencing and address pointer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r  <= FR_IDLE;
      repeat_r <= 1'b0;
      ptr_r    <= '0;
    end else if (frame_start) begin
      state_r  <= FR_ADDR;
      repeat_r <= page_ctrl_r[WRITE_MODE_BIT] && !wire4_sel;
    end else if (frame_stop) begin
      state_r  <= FR_IDLE;
    end else if (byte_taken) begin
      case (state_r)
        FR_ADDR: begin
          ptr_r   <= byte_data[LOCAL_W-1:0];
          state_r <= FR_DATA;
        end
        FR_DATA: begin
          if (repeat_r) begin
            state_r <= FR_ADDR;
          end else begin
            ptr_r <= ptr_r + 7'h01;
          end
        end
        default: state_r <= FR_IDLE;
      endcase
    end else if (rd_req && in_frame && !repeat_r) begin
      ptr_r <= ptr_r + 7'h01;
    end
  end

  // page control register, one copy seen from each of pages 0 to 2
  always_ff @(posedge clock) begin
    if (rst) begin
      page_ctrl_r <= PAGE_CTRL_RST;
    end else if (frame_stop && page_ctrl_r[AUTO_RETURN_BIT]) begin
      page_ctrl_r[PAGE_W-1:0] <= PAGE_ZERO;
    end else if (data_write && map_ok && is_page_ctrl) begin
      page_ctrl_r <= byte_data & PAGE_CTRL_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NUM_RW; i++) begin
        rw_regs_r[i] <= RW_RST;
      end
    end else if (data_write && rw_hit) begin
      rw_regs_r[rw_idx] <= byte_data;
    end
  end

  // read mux, status sampled in the read cycle
  always_comb begin
    rd_nxt = READ_NONE;
    if (map_ok) begin
      if (is_page_ctrl) begin
        rd_nxt = page_ctrl_r;
      end else if (cur_addr == INPUT_LEVEL_ADDR) begin
        rd_nxt = input_live;
      end else if (cur_addr == FAULT_POWER_ADDR) begin
        rd_nxt = fault_live;
      end else if (rw_hit) begin
        rd_nxt = rw_regs_r[rw_idx];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_r  <= READ_NONE;
      rd_valid_r <= 1'b0;
      ack_r      <= 1'b0;
    end else begin
      rd_valid_r <= rd_req && in_frame;
      ack_r      <= byte_taken;
      if (rd_req && in_frame) begin
        rd_data_r <= rd_nxt;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      page_sel_r   <= PAGE_ZERO;
      write_mode_r <= 1'b0;
    end else begin
      page_sel_r   <= page_ctrl_r[PAGE_W-1:0];
      write_mode_r <= page_ctrl_r[WRITE_MODE_BIT];
    end
  end

  assign rd_data    = rd_data_r;
  assign rd_valid   = rd_valid_r;
  assign byte_ack   = ack_r;
  assign page_sel   = page_sel_r;
  assign write_mode = write_mode_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  auto_return_a: assert property (frame_stop && page_ctrl_r[AUTO_RETURN_BIT]
    |=> page_ctrl_r[PAGE_W-1:0] == PAGE_ZERO ##1 page_sel == PAGE_ZERO)
    else $error("page not returned to zero after access");

  mode_select_a: assert property (frame_start && !wire4_sel
    |=> repeat_r == $past(page_ctrl_r[WRITE_MODE_BIT]))
    else $error("write style does not follow write-mode bit");

  wire4_page_a: assert property (frame_start && wire4_sel |=> !repeat_r)
    else $error("four-wire frame used repeated write");

  window_map_a: assert property (rd_req && in_frame && page_ctrl_r[PAGE_W-1:0] > PAGE_MAX
    |=> rd_valid && rd_data == READ_NONE)
    else $error("unmapped page returned data");

  status_live_a: assert property (rd_req && in_frame && map_ok && cur_addr == FAULT_POWER_ADDR
    |=> rd_data == $past(fault_live))
    else $error("status read not live");

  ilim_bits_a: assert property (rd_req && in_frame && map_ok && cur_addr == FAULT_POWER_ADDR
    |=> rd_data[CONV_B_ILIM_BIT] == $past(flt_s2_r[5])
        && rd_data[CONV_A_ILIM_BIT] == $past(flt_s2_r[4]))
    else $error("current limit status mismatch");

  thermal_bits_a: assert property (rd_req && in_frame && map_ok && cur_addr == FAULT_POWER_ADDR
    |=> rd_data[TSD_BIT] == $past(flt_s2_r[3]) && rd_data[TWARN_BIT] == $past(flt_s2_r[2]))
    else $error("thermal status mismatch");

  page_mirror_a: assert property (rd_req && in_frame && map_ok && is_page_ctrl
    |=> rd_data == $past(page_ctrl_r))
    else $error("page control not mirrored");

  repeat_alt_a: assert property (data_write && repeat_r |=> state_r == FR_ADDR)
    else $error("repeated write did not return to address");

  mode_held_a: assert property (in_frame && !frame_start |=> $stable(repeat_r))
    else $error("write style changed inside a frame");

  ptr_advance_a: assert property (data_write && !repeat_r
    |=> ptr_r == $past(ptr_r) + 7'h01 && byte_ack)
    else $error("page write pointer did not advance");

  // pins reach the status images two clocks late, once reset is two clocks gone
  ilim_b_live_a: assert property (!$past(rst) && !$past(rst, 2)
    |-> fault_live[CONV_B_ILIM_BIT] == $past(conv_b_current_limited, 2))
    else $error("converter B limit status not live");

  ilim_a_live_a: assert property (!$past(rst) && !$past(rst, 2)
    |-> fault_live[CONV_A_ILIM_BIT] == $past(conv_a_current_limited, 2))
    else $error("converter A limit status not live");

  tsd_live_a: assert property (!$past(rst) && !$past(rst, 2)
    |-> fault_live[TSD_BIT] == $past(thermal_shutdown_flag, 2))
    else $error("thermal shutdown status not live");

  twarn_live_a: assert property (!$past(rst) && !$past(rst, 2)
    |-> fault_live[TWARN_BIT] == $past(thermal_warn_flag, 2))
    else $error("thermal warning status not live");

  gen_live_a: assert property (!$past(rst) && !$past(rst, 2)
    |-> input_live[GEN_INPUTS-1:0] == $past(gen_input, 2))
    else $error("input level status not live");

  input_read_a: assert property (rd_req && in_frame && map_ok && cur_addr == INPUT_LEVEL_ADDR
    |=> rd_data == $past(input_live))
    else $error("input level read not live");

  // handshake answers come one cycle after the request
  read_answer_a: assert property (rd_req && in_frame |=> rd_valid)
    else $error("read got no answer");

  read_quiet_a: assert property (!(rd_req && in_frame) |=> !rd_valid && $stable(rd_data))
    else $error("read answer without a read");

  ack_pulse_a: assert property (byte_taken |=> byte_ack)
    else $error("taken byte not acknowledged");

  ack_quiet_a: assert property (!byte_taken |=> !byte_ack)
    else $error("acknowledge without a taken byte");

  // pointer and storage
  addr_capture_a: assert property (byte_taken && state_r == FR_ADDR
    |=> ptr_r == $past(byte_data[LOCAL_W-1:0]) && state_r == FR_DATA)
    else $error("address byte not taken as pointer");

  repeat_hold_a: assert property (data_write && repeat_r |=> $stable(ptr_r))
    else $error("repeated write moved the pointer");

  read_repeat_a: assert property (rd_req && in_frame && repeat_r && !byte_taken && !frame_start
    |=> $stable(ptr_r))
    else $error("read in repeated mode moved the pointer");

  ptr_read_a: assert property (rd_req && in_frame && !byte_taken && !frame_start && !frame_stop && !repeat_r
    |=> ptr_r == $past(ptr_r) + 7'h01)
    else $error("page mode read did not advance pointer");

  reg_store_a: assert property (data_write && rw_hit
    |=> rw_regs_r[$past(rw_idx)] == $past(byte_data))
    else $error("data byte not stored at pointer");

  rw_read_a: assert property (rd_req && in_frame && rw_hit
    |=> rd_data == $past(rw_regs_r[rw_idx]))
    else $error("stored register read back wrong");

  unmapped_write_a: assert property (data_write && !map_ok |=> $stable(page_ctrl_r))
    else $error("write through unmapped page changed page control");

  page_write_a: assert property (data_write && map_ok && is_page_ctrl
    |=> page_ctrl_r == ($past(byte_data) & PAGE_CTRL_MASK))
    else $error("page control write not taken");

  page_keep_a: assert property (frame_stop && !page_ctrl_r[AUTO_RETURN_BIT] |=> $stable(page_ctrl_r))
    else $error("page changed at stop without auto-return");

  return_keeps_a: assert property (frame_stop && page_ctrl_r[AUTO_RETURN_BIT]
    |=> page_ctrl_r[AUTO_RETURN_BIT] && page_ctrl_r[WRITE_MODE_BIT] == $past(page_ctrl_r[WRITE_MODE_BIT]))
    else $error("auto-return disturbed other page control bits");

  frame_open_a: assert property (frame_start |=> state_r == FR_ADDR)
    else $error("start did not open a frame");

  frame_close_a: assert property (frame_stop && !frame_start |=> state_r == FR_IDLE)
    else $error("stop did not close the frame");

endmodule : page_status_regs
`default_nettype wire

//--- tb/host_model.sv
// host side of the control link: frames, bytes and reads
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       clock,
  // requests
  output logic            frame_start,
  output logic            frame_stop,
  output logic            wire4_sel,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            rd_req,
  // answers
  input  wire logic       byte_ack,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data
);
  initial {frame_start, frame_stop, wire4_sel, byte_valid, byte_data, rd_req} = '0;
  // random gaps give prompt and slow hosts alike
  task automatic idle();
    repeat ($urandom_range(2, 0)) @(posedge clock);
  endtask : idle
  // the main loop only gives page control pages up to two; page three is written once at the end
  task automatic start(input logic w4);
    idle();
    @(posedge clock);
    frame_start <= 1'b1;
    wire4_sel   <= w4;
    @(posedge clock);
    frame_start <= 1'b0;
  endtask : start
  // write mode is set by a plain write closed with a stop
  task automatic stop();
    idle();
    @(posedge clock);
    frame_stop <= 1'b1;
    @(posedge clock);
    frame_stop <= 1'b0;
  endtask : stop
  task automatic send(input logic [7:0] b, output logic ack);
    @(posedge clock);
    byte_valid <= 1'b1;
    byte_data  <= b;
    @(posedge clock);
    byte_valid <= 1'b0;
    byte_data  <= ~b;
    #1 ack = byte_ack;
  endtask : send
  task automatic fetch(output logic [7:0] d, output logic v);
    @(posedge clock);
    rd_req <= 1'b1;
    @(posedge clock);
    rd_req <= 1'b0;
    #1 v = rd_valid;
    d = rd_data;
  endtask : fetch
endmodule : host_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench with a reference model of the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import page_status_pkg::*;
  logic        clock, rst, frame_start, frame_stop, wire4_sel, byte_valid, rd_req;
  logic        rd_valid, byte_ack, write_mode, ack, w4;
  logic [7:0]  byte_data, rd_data;
  logic [10:0] mon;
  logic [2:0]  page_sel;
  int          failures, n_compared, cycles, pc, ptr, wm, anext, a;
  int          mem [512];
  int          lt [8] = '{'h50, 'h51, 'h5e, 'h01, 'h04, 'h40, 'h46, 'h58};

  page_status_regs dut (.clock(clock), .rst(rst), .frame_start(frame_start), .frame_stop(frame_stop),
    .wire4_sel(wire4_sel), .byte_valid(byte_valid), .byte_data(byte_data), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .byte_ack(byte_ack), .gen_input(mon[4:0]),
    .conv_a_current_limited(mon[5]), .conv_b_current_limited(mon[6]), .thermal_shutdown_flag(mon[7]),
    .thermal_warn_flag(mon[8]), .conv_a_power_good(mon[9]), .conv_b_power_good(mon[10]),
    .page_sel(page_sel), .write_mode(write_mode));
  host_model host (.clock(clock), .frame_start(frame_start), .frame_stop(frame_stop),
    .wire4_sel(wire4_sel), .byte_valid(byte_valid), .byte_data(byte_data), .rd_req(rd_req),
    .byte_ack(byte_ack), .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic report_and_stop();
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_byte(nm, {7'h00, e}, {7'h00, g});
  endtask : chk_bit

  function automatic int full(int l);
    return (pc & 7) * 128 + l;
  endfunction : full
  function automatic bit is_rw(int ad);
    foreach (RW_ADDR[i]) if (RW_ADDR[i] == ad) return 1;
    return 0;
  endfunction : is_rw
  function automatic int m_read(int l);
    if ((pc & 7) > 2) return 0;
    if (l == 0) return pc;
    if (full(l) == 'h50) return {3'b0, mon[4:0]};
    if (full(l) == 'h51) return {2'b0, mon[6], mon[5], mon[7], mon[8], mon[10], mon[9]};
    if (is_rw(full(l))) return mem[full(l)];
    return 0;
  endfunction : m_read

  task automatic open_frame(input logic f4, input int ad);
    host.start(f4);
    wm = f4 ? 0 : pc[6];
    host.send(ad[7:0], ack);
    chk_bit("byte_ack", 1'b1, ack);
    ptr = ad & 'h7f;
    anext = 0;
  endtask : open_frame
  task automatic close_frame();
    host.stop();
    if (pc[7]) pc = pc & 'hf8;
    @(posedge clock);
    #1 chk_byte("page_sel", 8'(pc & 7), {5'h00, page_sel});
    chk_bit("write_mode", pc[6], write_mode);
  endtask : close_frame
  task automatic wr_frame(input logic f4, input int ad, input int n, input int v);
    int b;
    open_frame(f4, ad);
    repeat (n) begin
      b = (v >= 0) ? v : ($urandom & 'h7f) | 'h40;
      host.send(b[7:0], ack);
      chk_bit("byte_ack", 1'b1, ack);
      if (anext) ptr = b & 'h7f;
      else if (ptr == 0) pc = ((pc & 7) > 2) ? pc : b & 'hc7;
      else if (is_rw(full(ptr))) mem[full(ptr)] = b;
      if (!anext && wm == 0) ptr++;
      anext = wm ? !anext : 0;
    end
    close_frame();
  endtask : wr_frame
  task automatic rd_frame(input logic f4, input int ad, input int n);
    logic [7:0] d;
    logic       v;
    open_frame(f4, ad);
    repeat (n) begin
      host.fetch(d, v);
      chk_bit("rd_valid", 1'b1, v);
      chk_byte("rd_data", 8'(m_read(ptr)), d);
      if (wm == 0) ptr++;
    end
    close_frame();
  endtask : rd_frame

  initial begin
    rst = 1'b1;
    mon = '0;
    pc = 0;
    mem = '{default: 0};
    void'($urandom(30));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 chk_byte("page_sel", 8'h00, {5'h00, page_sel});
    host.send(8'h12, ack);
    chk_bit("byte_ack", 1'b0, ack);
    for (int it = 0; it < 40; it++) begin
      @(posedge clock);
      mon <= 11'($urandom);
      wr_frame(1'($urandom), 0, 1, ($urandom & 'hf8) | $urandom_range(2, 0));
      rd_frame(1'($urandom), 0, 1);
      w4 = 1'($urandom);
      a = lt[$urandom_range(7, 0)];
      wr_frame(w4, a, $urandom_range(3, 1), -1);
      rd_frame(1'($urandom), a, 3);
    end
    // production-only page value: nothing is mapped and page control is out of reach until reset
    wr_frame(1'b0, 0, 1, 'h03);
    rd_frame(1'b0, 'h51, 1);
    wr_frame(1'b1, 0, 1, 'h41);
    rd_frame(1'b0, 0, 1);
    @(posedge clock);
    rst <= 1'b1;
    mon <= 11'($urandom);
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    pc = 0;
    mem = '{default: 0};
    @(posedge clock);
    #1 chk_byte("page_sel", 8'h00, {5'h00, page_sel});
    rd_frame(1'b0, 'h51, 2);
    rd_frame(1'b1, 'h5e, 1);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
